// ### rtl/tmr8_pkg.sv
// Package of register map, field layout and constants for the three 8-bit timers
package tmr8_pkg;
    localparam int unsigned NUM_TIMERS = 3;
    // Byte addresses of the registers
    localparam logic [15:0] PORT3_DIR_ADDR  = 16'hff23;
    localparam logic [15:0] PORT7_DIR_ADDR  = 16'hff27;
    localparam logic [15:0] TMC0_ADDR       = 16'hff70;
    localparam logic [15:0] TCS0_ADDR       = 16'hff71;
    localparam logic [15:0] TMC1_ADDR       = 16'hff73;
    localparam logic [15:0] TCS1_ADDR       = 16'hff74;
    localparam logic [15:0] TMC2_ADDR       = 16'hff76;
    localparam logic [15:0] TCS2_ADDR       = 16'hff77;
    // Extra registers: compare values and counter readback
    localparam logic [15:0] CMP0_ADDR       = 16'hff80;
    localparam logic [15:0] CMP1_ADDR       = 16'hff84;
    localparam logic [15:0] CMP2_ADDR       = 16'hff88;
    localparam logic [15:0] CNT0_ADDR       = 16'hff90;
    localparam logic [15:0] CNT1_ADDR       = 16'hff94;
    localparam logic [15:0] CNT2_ADDR       = 16'hff98;
    // Mode register fields
    localparam int unsigned RUN_BIT   = 7;
    localparam int unsigned MODE_BIT  = 6;
    localparam int unsigned SET_BIT   = 3;
    localparam int unsigned CLR_BIT   = 2;
    localparam int unsigned INV_BIT   = 1;
    localparam int unsigned OE_BIT    = 0;
    localparam logic [7:0]  TMC_WMASK = 8'hc3;
    localparam logic [7:0]  TCS_WMASK = 8'h07;
    // Reset values and fixed port direction bits
    localparam logic [7:0]  TMC_RESET = 8'h00;
    localparam logic [7:0]  TCS_RESET = 8'h00;
    localparam logic [7:0]  PDIR_RESET = 8'hff;
    localparam logic [7:0]  PORT3_FIXED = 8'he0;
    localparam logic [7:0]  PORT7_FIXED = 8'hf0;
    localparam logic [7:0]  CMP_RESET = 8'h00;
    // Prescaler width (covers divide by 2048)
    localparam int unsigned PRE_W = 11;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic       run;
        logic       pwm;
        logic       inv;
        logic       oe;
    } tmc_s;
endpackage : tmr8_pkg

// ### rtl/tmr8_top.sv
// Three 8-bit timer/event counters behind an AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tmr8_top
    import tmr8_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // External count inputs (asynchronous pins)
    input  wire logic [2:0]  external_count_input,
    // Timer output pins and their enables
    output logic [2:0]       timer_output_pin,
    output logic [2:0]       timer_output_oe,
    // Match interrupt pulses
    output logic [2:0]       match_interrupt,
    // Port direction registers
    output logic [7:0]       port3_direction,
    output logic [7:0]       port7_direction
);

    // Bus slave state
    logic        aw_have_q, aw_have_d;
    logic        w_have_q, w_have_d;
    logic [15:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0]  w_strb_q, w_strb_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        rvalid_q, rvalid_d;
    logic [1:0]  rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        arready_q, arready_d;
    logic        awready_q, awready_d;
    logic        wready_q, wready_d;

    // Register state
    logic [7:0]  pdir3_q, pdir3_d;
    logic [7:0]  pdir7_q, pdir7_d;
    tmc_s        tmc_q [NUM_TIMERS];
    tmc_s        tmc_d [NUM_TIMERS];
    logic [2:0]  tcs_q [NUM_TIMERS];
    logic [2:0]  tcs_d [NUM_TIMERS];
    logic [7:0]  cmp_q [NUM_TIMERS];
    logic [7:0]  cmp_d [NUM_TIMERS];
    logic [2:0]  ff_set;
    logic [2:0]  ff_clr;

    logic        do_write;
    logic [7:0]  wbyte;
    logic        wlane;
    logic        rd_hit;
    logic [7:0]  rbyte;
    logic [7:0]  cnt_view [NUM_TIMERS];

    // Write happens once both address and data are held and no write response is pending
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    assign wbyte = w_data_q[8*aw_addr_q[1:0] +: 8];
    assign wlane = w_strb_q[aw_addr_q[1:0]];

    // Slave handshake and register write decode
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        aw_addr_d = aw_addr_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        pdir3_d   = pdir3_q;
        pdir7_d   = pdir7_q;
        tmc_d     = tmc_q;
        tcs_d     = tcs_q;
        cmp_d     = cmp_q;
        ff_set    = 3'b000;
        ff_clr    = 3'b000;
        if (s_axi_awvalid && !aw_have_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_q) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            if (wlane) begin
                unique case (aw_addr_q)
                    PORT3_DIR_ADDR: pdir3_d = wbyte | PORT3_FIXED;
                    PORT7_DIR_ADDR: pdir7_d = wbyte | PORT7_FIXED;
                    CMP0_ADDR:      cmp_d[0] = wbyte;
                    CMP1_ADDR:      cmp_d[1] = wbyte;
                    CMP2_ADDR:      cmp_d[2] = wbyte;
                    default: begin
                        bresp_d = RESP_SLVERR;
                        for (int i = 0; i < NUM_TIMERS; i++) begin
                            if (aw_addr_q == TMC0_ADDR + 16'(3 * i)) begin
                                bresp_d       = RESP_OKAY;
                                tmc_d[i].run  = wbyte[RUN_BIT];
                                tmc_d[i].pwm  = wbyte[MODE_BIT];
                                tmc_d[i].inv  = wbyte[INV_BIT];
                                tmc_d[i].oe   = wbyte[OE_BIT];
                                ff_set[i]     = wbyte[SET_BIT] && !wbyte[CLR_BIT];
                                ff_clr[i]     = wbyte[CLR_BIT] && !wbyte[SET_BIT];
                            end
                            if (aw_addr_q == TCS0_ADDR + 16'(3 * i)) begin
                                bresp_d  = RESP_OKAY;
                                tcs_d[i] = wbyte[2:0];
                            end
                        end
                    end
                endcase
            end
        end
        // Ready flags follow the holding flags
        awready_d = !aw_have_d;
        wready_d  = !w_have_d;
    end

    // Read mux
    always_comb begin
        rd_hit = 1'b1;
        rbyte  = 8'h00;
        unique case (s_axi_araddr)
            PORT3_DIR_ADDR: rbyte = pdir3_q;
            PORT7_DIR_ADDR: rbyte = pdir7_q;
            TMC0_ADDR, TMC1_ADDR, TMC2_ADDR: begin
                for (int i = 0; i < NUM_TIMERS; i++) begin
                    if (s_axi_araddr == TMC0_ADDR + 16'(3 * i)) begin
                        rbyte = {tmc_q[i].run, tmc_q[i].pwm, 4'h0, tmc_q[i].inv, tmc_q[i].oe};
                    end
                end
            end
            TCS0_ADDR: rbyte = {5'h00, tcs_q[0]};
            TCS1_ADDR: rbyte = {5'h00, tcs_q[1]};
            TCS2_ADDR: rbyte = {5'h00, tcs_q[2]};
            CMP0_ADDR: rbyte = cmp_q[0];
            CMP1_ADDR: rbyte = cmp_q[1];
            CMP2_ADDR: rbyte = cmp_q[2];
            CNT0_ADDR: rbyte = cnt_view[0];
            CNT1_ADDR: rbyte = cnt_view[1];
            CNT2_ADDR: rbyte = cnt_view[2];
            default:   rd_hit = 1'b0;
        endcase
    end

    // Read channel: address taken first, data held until accepted
    always_comb begin
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
        if (s_axi_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rresp_d   = rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_d   = {24'h000000, rbyte} << (8 * s_axi_araddr[1:0]);
        end
    end

    // Bus and register flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= 16'h0000;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= 32'h00000000;
            arready_q <= 1'b1;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            pdir3_q   <= PDIR_RESET;
            pdir7_q   <= PDIR_RESET;
            for (int i = 0; i < NUM_TIMERS; i++) begin
                tmc_q[i] <= tmc_s'(TMC_RESET[3:0]);
                tcs_q[i] <= TCS_RESET[2:0];
                cmp_q[i] <= CMP_RESET;
            end
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            aw_addr_q <= aw_addr_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            arready_q <= arready_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            pdir3_q   <= pdir3_d;
            pdir7_q   <= pdir7_d;
            tmc_q     <= tmc_d;
            tcs_q     <= tcs_d;
            cmp_q     <= cmp_d;
        end
    end

    assign s_axi_awready   = awready_q;
    assign s_axi_wready    = wready_q;
    assign s_axi_bvalid    = bvalid_q;
    assign s_axi_bresp     = bresp_q;
    assign s_axi_arready   = arready_q;
    assign s_axi_rvalid    = rvalid_q;
    assign s_axi_rresp     = rresp_q;
    assign s_axi_rdata     = rdata_q;
    assign port3_direction = pdir3_q;
    assign port7_direction = pdir7_q;

    // One counter channel per timer
    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
        logic [1:0]       sync_q, sync_d;
        logic             ext_prev_q, ext_prev_d;
        logic [PRE_W-1:0] pre_q, pre_d;
        logic [7:0]       cnt_q, cnt_d;
        logic             ff_q, ff_d;
        logic             pwm_act_q, pwm_act_d;
        logic             irq_q, irq_d;
        logic             pin_q, pin_d;
        logic             oe_q, oe_d;
        logic             tick;
        logic             match;
        logic [3:0]       shift;
        logic [PRE_W-1:0] pmask;

        // Divide exponent per code; timer 2 sits one higher, dividing twice as far
        always_comb begin
            shift = 4'(2 * (32'(tcs_q[g]) - 2) + (g == 2 ? 1 : 0));
            pmask = PRE_W'((32'h1 << shift) - 1);
        end

        // Count tick selection and counter update
        always_comb begin
            sync_d     = {sync_q[0], external_count_input[g]};
            ext_prev_d = sync_q[1];
            pre_d      = pre_q;
            cnt_d      = cnt_q;
            ff_d       = ff_q;
            pwm_act_d  = pwm_act_q;
            irq_d      = 1'b0;
            tick       = 1'b0;
            match      = 1'b0;
            if (tcs_q[g] == 3'd0) begin
                tick = ext_prev_q && !sync_q[1];
            end else if (tcs_q[g] == 3'd1) begin
                tick = !ext_prev_q && sync_q[1];
            end else begin
                tick = (pre_q & pmask) == pmask;
            end
            if (!tmc_q[g].run) begin
                pre_d     = '0;
                cnt_d     = 8'h00;
                pwm_act_d = 1'b0;
                tick      = 1'b0;
            end else begin
                pre_d = pre_q + PRE_W'(1);
            end
            match = tick && (cnt_q == cmp_q[g]);
            if (tick) begin
                if (!tmc_q[g].pwm) begin
                    if (match) begin
                        cnt_d = 8'h00;
                        irq_d = 1'b1;
                        if (tmc_q[g].inv) begin
                            ff_d = !ff_q;
                        end
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                    end
                end else begin
                    cnt_d = cnt_q + 8'h01;
                    if (match) begin
                        pwm_act_d = 1'b0;
                    end else if (cnt_q == 8'hff) begin
                        pwm_act_d = 1'b1;
                    end
                end
            end
            if (ff_set[g]) begin
                ff_d = 1'b1;
            end else if (ff_clr[g]) begin
                ff_d = 1'b0;
            end
            oe_d = tmc_q[g].oe;
            if (tmc_q[g].pwm) begin
                pin_d = tmc_q[g].oe && ((pwm_act_d && tmc_q[g].run) ^ tmc_q[g].inv);
            end else begin
                pin_d = tmc_q[g].oe && ff_d;
            end
        end

        // Channel flops
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sync_q     <= 2'b00;
                ext_prev_q <= 1'b0;
                pre_q      <= '0;
                cnt_q      <= 8'h00;
                ff_q       <= 1'b0;
                pwm_act_q  <= 1'b0;
                irq_q      <= 1'b0;
                pin_q      <= 1'b0;
                oe_q       <= 1'b0;
            end else begin
                sync_q     <= sync_d;
                ext_prev_q <= ext_prev_d;
                pre_q      <= pre_d;
                cnt_q      <= cnt_d;
                ff_q       <= ff_d;
                pwm_act_q  <= pwm_act_d;
                irq_q      <= irq_d;
                pin_q      <= pin_d;
                oe_q       <= oe_d;
            end
        end

        assign cnt_view[g]         = cnt_q;
        assign match_interrupt[g]  = irq_q;
        assign timer_output_pin[g] = pin_q;
        assign timer_output_oe[g]  = oe_q;
    end

endmodule : tmr8_top

// ### verification/tmr8_properties.sv
// Port-level assertions for the three 8-bit timers
`timescale 1ns/1ps
module tmr8_properties
    import tmr8_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Timer side
    input wire logic [2:0]  timer_output_pin,
    input wire logic [2:0]  timer_output_oe,
    input wire logic [2:0]  match_interrupt,
    input wire logic [7:0]  port3_direction,
    input wire logic [7:0]  port7_direction
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Reset state, pin gating and fixed direction bits
    chk_reset_state: assert property (
        $rose(aresetn) |-> port3_direction == 8'hff && port7_direction == 8'hff && timer_output_oe == 3'b000
        && timer_output_pin == 3'b000 && match_interrupt == 3'b000) else $error("outputs not at reset state");
    chk_dir_fixed: assert property (
        port3_direction[7:5] == 3'b111 && port7_direction[7:4] == 4'hf) else $error("fixed direction bits wrong");
    chk_pin_gated: assert property (
        (timer_output_pin & ~timer_output_oe) == 3'b000) else $error("pin driven while output disabled");
    // Bus timing
    chk_write_walk: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid) else $error("write answer out of step");
    chk_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_b_release: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response not released");
    chk_read_answer: assert property (
        s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid) else $error("read answer late");
    chk_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed while waiting");
    chk_r_release: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read data not released");
    chk_ar_one_deep: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read address taken while data pending");
endmodule : tmr8_properties

bind tmr8_top tmr8_properties i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_output_pin, .timer_output_oe,
    .match_interrupt, .port3_direction, .port7_direction);

// ### verification/tmr8_top_tb.sv
// Self-checking bench for the three 8-bit timers
`timescale 1ns/1ps
module tmr8_top_tb
    import tmr8_pkg::*;
;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [15:0] awaddr = '0, araddr = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = '0;
    logic [2:0]  ext = '0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [2:0]  pin, oe, irq;
    logic [7:0]  dir3, dir7;
    int          err_total = 0, comparisons = 0, c, h;
    int          irq_cnt [3] = '{0, 0, 0};
    logic [31:0] d;
    logic [1:0]  r;
    localparam logic [15:0] TMC_A [3] = '{TMC0_ADDR, TMC1_ADDR, TMC2_ADDR};
    localparam logic [15:0] TCS_A [3] = '{TCS0_ADDR, TCS1_ADDR, TCS2_ADDR};
    localparam logic [15:0] CMP_A [3] = '{CMP0_ADDR, CMP1_ADDR, CMP2_ADDR};
    localparam logic [15:0] CNT_A [3] = '{CNT0_ADDR, CNT1_ADDR, CNT2_ADDR};
    localparam logic [15:0] RST_A [11] = '{PORT3_DIR_ADDR, PORT7_DIR_ADDR, TMC0_ADDR, TCS0_ADDR, TMC1_ADDR,
        TCS1_ADDR, TMC2_ADDR, TCS2_ADDR, CMP0_ADDR, CMP1_ADDR, CMP2_ADDR};
    localparam logic [7:0]  LV_W [4] = '{8'h09, 8'h01, 8'h05, 8'h01};

    tmr8_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .external_count_input(ext),
        .timer_output_pin(pin), .timer_output_oe(oe), .match_interrupt(irq), .port3_direction(dir3),
        .port7_direction(dir7));

    // Clock source
    initial begin
        forever #2.5 aclk = ~aclk;
    end

    // Match pulse tally per timer
    always @(posedge aclk) begin
        for (int i = 0; i < 3; i++) irq_cnt[i] <= irq_cnt[i] + int'(irq[i] === 1'b1);
    end

    task automatic test_done;
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Write one byte register; address and data offered together
    task automatic axi_wr(input logic [15:0] a, input logic [7:0] v, output logic [1:0] resp);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, v} << (8 * a[1:0]);
        wstrb   <= 4'h1 << a[1:0];
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    // Read one byte register; ready raised with the request
    task automatic axi_rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata >> (8 * a[1:0]);
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        logic [1:0] rs;
        axi_wr(a, v, rs);
        chk("write response", RESP_OKAY, rs);
    endtask : wr

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        logic [31:0] v;
        logic [1:0]  rs;
        axi_rd(a, v, rs);
        chk($sformatf("register %h", a), {24'h0, e}, v);
        chk("read response", RESP_OKAY, rs);
    endtask : rd_chk

    task automatic wait_irq(input int t, output int n);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (irq[t] !== 1'b1);
    endtask : wait_irq

    // Interval between match pulses, with optional toggling output
    task automatic period_chk(input int t, input logic [7:0] code, input logic [7:0] n, input logic [7:0] mode);
        int   cy;
        int   div;
        logic p0;
        div = (t == 2 ? 2 : 1) << (2 * (code - 2));
        wr(TMC_A[t], 8'h00);
        rd_chk(CNT_A[t], 8'h00);
        wr(TCS_A[t], code);
        rd_chk(TCS_A[t], code);
        wr(CMP_A[t], n);
        wr(TMC_A[t], mode);
        wait_irq(t, cy);
        p0 = pin[t];
        wait_irq(t, cy);
        chk("match period", (n + 1) * div, cy);
        if (mode[1]) chk("toggle", {31'h0, ~p0}, {31'h0, pin[t]});
    endtask : period_chk

    // Hang guard
    initial begin
        repeat (90000) @(posedge aclk);
        err_total++;
        test_done();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 11; i++) rd_chk(RST_A[i], i < 2 ? 8'hff : 8'h00);
        axi_rd(16'hff40, d, r);
        chk("unmapped data", 32'h0, d);
        chk("unmapped read", RESP_SLVERR, r);
        axi_wr(16'hff40, 8'h5a, r);
        chk("unmapped write", RESP_SLVERR, r);
        axi_wr(CNT0_ADDR, 8'h55, r);
        rd_chk(CNT0_ADDR, 8'h00);
        wr(PORT3_DIR_ADDR, 8'h00);
        rd_chk(PORT3_DIR_ADDR, 8'he0);
        chk("port3 pins", 8'he0, dir3);
        wr(PORT7_DIR_ADDR, 8'h05);
        rd_chk(PORT7_DIR_ADDR, 8'hf5);
        // Output flop set, keep, clear, keep
        for (int k = 0; k < 4; k++) begin
            wr(TMC2_ADDR, LV_W[k]);
            repeat (2) @(posedge aclk);
            chk("flop level", k < 2, pin[2]);
            chk("output enable", 1, oe[2]);
        end
        wr(TMC2_ADDR, 8'h4b);
        rd_chk(TMC2_ADDR, 8'h43);
        wr(TMC2_ADDR, 8'h00);
        for (int t = 0; t < 3; t++) begin
            for (int k = 2; k < 8; k++) period_chk(t, k[7:0], 8'h02, k[0] ? 8'h83 : 8'h80);
        end
        period_chk(0, 8'h02, 8'h00, 8'h80);
        period_chk(0, 8'h02, 8'hff, 8'h83);
        // Event counting on both edge kinds
        for (int k = 0; k < 2; k++) begin
            wr(TMC1_ADDR, 8'h00);
            ext[1] <= (k == 0);
            wr(TCS1_ADDR, k[7:0]);
            wr(CMP1_ADDR, 8'h02);
            wr(TMC1_ADDR, 8'h80);
            c = irq_cnt[1];
            repeat (6) begin
                repeat (8) @(posedge aclk);
                ext[1] <= (k == 1);
                repeat (8) @(posedge aclk);
                ext[1] <= (k == 0);
            end
            repeat (8) @(posedge aclk);
            chk("event matches", c + 2, irq_cnt[1]);
        end
        // Free-running pulse width, both polarities
        wr(TMC0_ADDR, 8'h00);
        wr(TCS0_ADDR, 8'h02);
        wr(CMP0_ADDR, 8'h3f);
        for (int k = 0; k < 2; k++) begin
            c = irq_cnt[0];
            wr(TMC0_ADDR, k ? 8'hc3 : 8'hc1);
            repeat (600) @(posedge aclk);
            h = 0;
            repeat (512) begin
                @(posedge aclk);
                h += int'(pin[0] === 1'b1);
            end
            chk("active width", k ? 384 : 128, h);
            chk("no match pulse", c, irq_cnt[0]);
            wr(TMC0_ADDR, k ? 8'h43 : 8'h41);
            repeat (4) @(posedge aclk);
            chk("stopped level", k, pin[0]);
        end
        test_done();
    end
endmodule : tmr8_top_tb
